// ===== nvac_pkg.sv
`default_nettype none
package nvac_pkg;
   // Register select codes on the special-function port
   localparam logic [2:0] NVAC_SEL_CTRL  = 3'h0;
   localparam logic [2:0] NVAC_SEL_KEY   = 3'h1;
   localparam logic [2:0] NVAC_SEL_BUF   = 3'h2;
   localparam logic [2:0] NVAC_SEL_IDXL  = 3'h3;
   localparam logic [2:0] NVAC_SEL_IDXH  = 3'h4;
   // Control register bit positions
   localparam int NVAC_B_FLASH  = 7;
   localparam int NVAC_B_CFG    = 6;
   localparam int NVAC_B_ROW    = 4;
   localparam int NVAC_B_FAULT  = 3;
   localparam int NVAC_B_GATE   = 2;
   localparam int NVAC_B_WR     = 1;
   localparam int NVAC_B_RD     = 0;
   // Unlock keys and reset values
   localparam logic [7:0] NVAC_KEY_FIRST  = 8'h55;
   localparam logic [7:0] NVAC_KEY_SECOND = 8'haa;
   localparam logic [7:0] NVAC_ERASED     = 8'hff;
   localparam logic [7:0] NVAC_RST_BYTE   = 8'h00;
   localparam int NVAC_DEPTH = 1024;
   localparam int NVAC_AW    = 10;
   // Self-timed write; the real figure varies with supply and temperature
   localparam int NVAC_CLK_PERIOD_NS = 25;
   localparam int NVAC_WRITE_TIME_NS = 4000;
   localparam int NVAC_WRITE_CYCLES  = NVAC_WRITE_TIME_NS / NVAC_CLK_PERIOD_NS;
   localparam int NVAC_PHASE_CYCLES  = NVAC_WRITE_CYCLES / 2;
   typedef enum logic [1:0] {
      NVAC_LK_IDLE  = 2'b00,
      NVAC_LK_FIRST = 2'b01,
      NVAC_LK_ARMED = 2'b11
   } nvac_lock_t;
   typedef enum logic [1:0] {
      NVAC_PH_IDLE  = 2'b00,
      NVAC_PH_ERASE = 2'b01,
      NVAC_PH_PROG  = 2'b11
   } nvac_phase_t;
endpackage
`default_nettype wire

// ===== nvac_top.sv
`timescale 1ns/1ps
`default_nettype none
module nvac_top
   import nvac_pkg::*;
#(
   parameter int PHASE_CYCLES = NVAC_PHASE_CYCLES
) (
   input  wire logic       CLK,
   input  wire logic       RESET,
   input  wire logic       POR_RESET,
   input  wire logic       CE,
   input  wire logic [2:0] SFR_SEL,
   input  wire logic       SFR_WE,
   input  wire logic       SFR_RE,
   input  wire logic [7:0] SFR_WDATA,
   input  wire logic       DONE_FLAG_CLR,
   output logic      [7:0] SFR_RDATA,
   output logic            NV_DONE_FLAG,
   output logic            NV_BUSY
);
   localparam logic [15:0] PHASE_LAST = 16'(PHASE_CYCLES - 1);
   localparam logic [16:0] BUSY_LAST  = 17'(2 * PHASE_CYCLES - 1);

   logic [7:0]  mem_q [0:NVAC_DEPTH-1];
   logic [7:0]  buf_q;
   logic [7:0]  idx_low_q;
   logic [7:0]  idx_high_q;
   logic        flash_q;
   logic        cfg_q;
   logic        row_q;
   logic        fault_q;
   logic        gate_q;
   logic        wr_q;
   logic        rd_q;
   logic        done_q;
   logic [7:0]  rdata_q;
   logic [15:0] cnt_q;
   logic [16:0] busy_len_q;
   nvac_lock_t  lock_q;
   nvac_phase_t phase_q;
   logic        ctrl_we;
   logic        trig_req;
   logic        start_ok;
   logic        start;
   logic        phase_end;
   logic        done_pulse;
   logic        to_eeprom;
   logic        rd_req;
   logic [9:0]  addr;

   function automatic logic [9:0] nv_addr(input logic [7:0] hi, input logic [7:0] lo);
      return {hi[1:0], lo};
   endfunction

   function automatic logic [7:0] ctrl_image();
      return {flash_q, cfg_q, 1'b0, row_q, fault_q, gate_q, wr_q, rd_q};
   endfunction

   assign addr       = nv_addr(idx_high_q, idx_low_q);
   assign ctrl_we    = CE && SFR_WE && SFR_SEL == NVAC_SEL_CTRL && !wr_q;
   assign trig_req   = ctrl_we && SFR_WDATA[NVAC_B_WR];
   // Enable is the stored value, so one write setting both never starts
   assign start_ok   = lock_q == NVAC_LK_ARMED && gate_q;
   assign start      = trig_req && start_ok;
   assign phase_end  = CE && wr_q && cnt_q == 16'h0000;
   assign done_pulse = phase_end && phase_q == NVAC_PH_PROG;
   assign to_eeprom  = !flash_q && !cfg_q;
   // A read asked for by the write that starts a cycle would change the locked buffer
   assign rd_req     = ctrl_we && SFR_WDATA[NVAC_B_RD] && !start
                       && !SFR_WDATA[NVAC_B_FLASH] && !SFR_WDATA[NVAC_B_CFG];

   // Unlock sequence
   always_ff @(posedge CLK) begin
      if (POR_RESET || RESET) begin
         lock_q <= NVAC_LK_IDLE;
      end else if (CE && (SFR_WE || SFR_RE)) begin
         if (SFR_WE && SFR_SEL == NVAC_SEL_KEY && SFR_WDATA == NVAC_KEY_FIRST) begin
            lock_q <= NVAC_LK_FIRST;
         end else if (SFR_WE && SFR_SEL == NVAC_SEL_KEY && SFR_WDATA == NVAC_KEY_SECOND
                      && lock_q == NVAC_LK_FIRST) begin
            lock_q <= NVAC_LK_ARMED;
         end else begin
            lock_q <= NVAC_LK_IDLE;
         end
      end
   end

   // Control register
   always_ff @(posedge CLK) begin
      if (POR_RESET) begin
         flash_q <= 1'b0;
         cfg_q   <= 1'b0;
         row_q   <= 1'b0;
         fault_q <= 1'b0;
         gate_q  <= 1'b0;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
      end else if (RESET) begin
         // Flash and config selects survive so software can trace the fault
         row_q  <= 1'b0;
         gate_q <= 1'b0;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         if (wr_q) begin
            fault_q <= 1'b1;
         end
      end else if (CE) begin
         rd_q <= 1'b0;
         if (done_pulse) begin
            wr_q    <= 1'b0;
            fault_q <= 1'b0;
            row_q   <= 1'b0;
         end
         if (ctrl_we) begin
            flash_q <= SFR_WDATA[NVAC_B_FLASH];
            cfg_q   <= SFR_WDATA[NVAC_B_CFG];
            row_q   <= SFR_WDATA[NVAC_B_ROW];
            // Raising the gate arms the fault; a clean completion, or a control write with gate, fault and write bits clear, clears it
            fault_q <= SFR_WDATA[NVAC_B_FAULT] || SFR_WDATA[NVAC_B_GATE];
            gate_q  <= SFR_WDATA[NVAC_B_GATE];
            if (rd_req) begin
               rd_q <= 1'b1;
            end
            if (trig_req) begin
               // Start or improper attempt both leave the fault set
               fault_q <= 1'b1;
               wr_q    <= start_ok;
            end
         end
      end
   end

   // Self-timed erase then program
   always_ff @(posedge CLK) begin
      if (POR_RESET || RESET) begin
         phase_q <= NVAC_PH_IDLE;
         cnt_q   <= 16'h0000;
      end else if (CE) begin
         if (start) begin
            phase_q <= NVAC_PH_ERASE;
            cnt_q   <= PHASE_LAST;
         end else if (phase_end && phase_q == NVAC_PH_ERASE) begin
            phase_q <= NVAC_PH_PROG;
            cnt_q   <= PHASE_LAST;
         end else if (done_pulse) begin
            phase_q <= NVAC_PH_IDLE;
         end else if (wr_q) begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end

   // Array: flash and config targets are timed but live outside this block
   always_ff @(posedge CLK) begin
      if (CE && to_eeprom && phase_end) begin
         if (phase_q == NVAC_PH_ERASE) begin
            mem_q[addr] <= NVAC_ERASED;
         end else begin
            mem_q[addr] <= buf_q;
         end
      end
   end

   // Byte buffer and index registers
   always_ff @(posedge CLK) begin
      if (POR_RESET) begin
         buf_q      <= NVAC_RST_BYTE;
         idx_low_q  <= NVAC_RST_BYTE;
         idx_high_q <= NVAC_RST_BYTE;
      end else if (CE) begin
         if (rd_q) begin
            buf_q <= mem_q[addr];
         end else if (SFR_WE && SFR_SEL == NVAC_SEL_BUF && !wr_q) begin
            buf_q <= SFR_WDATA;
         end
         if (SFR_WE && SFR_SEL == NVAC_SEL_IDXL && !wr_q) begin
            idx_low_q <= SFR_WDATA;
         end
         if (SFR_WE && SFR_SEL == NVAC_SEL_IDXH && !wr_q) begin
            idx_high_q <= SFR_WDATA;
         end
      end
   end

   // Completion flag: a completion in the clear cycle wins
   always_ff @(posedge CLK) begin
      if (POR_RESET) begin
         done_q <= 1'b0;
      end else if (CE) begin
         if (done_pulse) begin
            done_q <= 1'b1;
         end else if (DONE_FLAG_CLR) begin
            done_q <= 1'b0;
         end
      end
   end

   // Read port
   always_ff @(posedge CLK) begin
      if (POR_RESET) begin
         rdata_q <= NVAC_RST_BYTE;
      end else if (CE && SFR_RE) begin
         unique case (SFR_SEL)
            NVAC_SEL_CTRL: rdata_q <= ctrl_image();
            NVAC_SEL_BUF:  rdata_q <= buf_q;
            NVAC_SEL_IDXL: rdata_q <= idx_low_q;
            NVAC_SEL_IDXH: rdata_q <= idx_high_q;
            default:       rdata_q <= NVAC_RST_BYTE;
         endcase
      end
   end

   assign SFR_RDATA    = rdata_q;
   assign NV_DONE_FLAG = done_q;
   assign NV_BUSY      = wr_q;

   // Length of the running write, kept only for the timing checks below
   always_ff @(posedge CLK) begin
      if (POR_RESET || RESET) begin
         busy_len_q <= 17'h00000;
      end else if (CE) begin
         busy_len_q <= wr_q ? busy_len_q + 17'h00001 : 17'h00000;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (POR_RESET || RESET);

   a_start_needs_keys: assert property ($rose(wr_q) |-> $past(lock_q) == NVAC_LK_ARMED)
      else $error("write started without unlock");
   a_start_needs_gate: assert property ($rose(wr_q) |-> $past(gate_q))
      else $error("write started without prior enable");
   a_read_next_cycle: assert property (rd_q && CE |=>
      buf_q == $past(mem_q[addr]) && rd_q == $past(rd_req))
      else $error("read byte not loaded");
   a_read_blocked: assert property (ctrl_we
      && (SFR_WDATA[NVAC_B_FLASH] || SFR_WDATA[NVAC_B_CFG]) |=> !rd_q)
      else $error("read set for flash or config");
   a_fault_busy: assert property (wr_q |-> fault_q)
      else $error("fault clear during write");
   a_done_sets_flag: assert property (done_pulse |=> NV_DONE_FLAG && !wr_q && !fault_q)
      else $error("completion not flagged");
   a_busy_lock: assert property (wr_q && SFR_WE |=> $stable(buf_q)
      && $stable(idx_low_q) && $stable(idx_high_q) && $stable(flash_q) && $stable(gate_q))
      else $error("register changed during write");
   a_key_reads_zero: assert property (CE && SFR_RE && SFR_SEL == NVAC_SEL_KEY
      |=> SFR_RDATA == 8'h00)
      else $error("key port read nonzero");
   a_gate_held: assert property (gate_q && !ctrl_we |=> gate_q)
      else $error("enable cleared by hardware");
   a_timer_bound: assert property (wr_q |-> cnt_q <= PHASE_LAST)
      else $error("write timer out of range");
   a_other_disarms: assert property (CE && (SFR_WE ? SFR_SEL != NVAC_SEL_KEY : SFR_RE)
      |=> lock_q == NVAC_LK_IDLE)
      else $error("unlock survived another access");
   a_row_cleared: assert property (done_pulse |=> !row_q)
      else $error("row erase select survived completion");
   a_bit5_zero: assert property (CE && SFR_RE && SFR_SEL == NVAC_SEL_CTRL
      |=> !SFR_RDATA[5])
      else $error("control bit 5 read nonzero");
   a_trigger_held: assert property (wr_q && !done_pulse |=> wr_q)
      else $error("write trigger dropped early");
   a_erase_first: assert property (phase_end && phase_q == NVAC_PH_ERASE && to_eeprom
      |=> mem_q[$past(addr)] == NVAC_ERASED)
      else $error("cell not erased before programming");
   a_cell_programmed: assert property (done_pulse && to_eeprom
      |=> mem_q[$past(addr)] == $past(buf_q))
      else $error("cell not programmed with buffer");
   a_start_state: assert property (start
      |=> wr_q && fault_q && phase_q == NVAC_PH_ERASE)
      else $error("trigger did not start erase");
   a_gate_fault: assert property (ctrl_we && SFR_WDATA[NVAC_B_GATE] |=> fault_q)
      else $error("fault not set with enable gate");
   a_bad_attempt: assert property (trig_req && !start_ok |=> !wr_q && fault_q)
      else $error("improper trigger started a write");
   a_done_held: assert property (NV_DONE_FLAG && !DONE_FLAG_CLR |=> NV_DONE_FLAG)
      else $error("completion flag lost without clear");
   a_write_length: assert property (wr_q |-> busy_len_q <= BUSY_LAST)
      else $error("self-timed write overran");
   a_done_on_time: assert property (done_pulse |-> busy_len_q == BUSY_LAST)
      else $error("write finished off its timed length");

   c_eeprom_read:  cover property (rd_q ##1 !rd_q);
   c_eeprom_write: cover property (start && to_eeprom ##[1:1000] done_pulse);
   c_done_clear:   cover property (NV_DONE_FLAG && DONE_FLAG_CLR ##1 !NV_DONE_FLAG);
   c_bad_attempt:  cover property (trig_req && !start_ok);
   c_row_erase:    cover property (start && row_q && flash_q);
endmodule
`default_nettype wire

// ===== nvac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nvac_top_tb
   import nvac_pkg::*;
();
   logic       clk   = 1'b0;
   logic       rst   = 1'b1;
   logic       por   = 1'b1;
   logic       we    = 1'b0;
   logic       re    = 1'b0;
   logic       dclr  = 1'b0;
   logic       ce    = 1'b1;
   logic [2:0] sel   = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] d;
   logic       done;
   logic       busy;
   int         failures  = 0;
   int         cmp_count = 0;
   int         cyc       = 0;
   // Short phases keep the run brief; a write is busy for two phases
   localparam int PHASE = 2;

   always #12.5 clk = ~clk;

   nvac_top #(.PHASE_CYCLES(PHASE)) DUT (
      .CLK(clk), .RESET(rst), .POR_RESET(por), .CE(ce), .SFR_SEL(sel),
      .SFR_WE(we), .SFR_RE(re), .SFR_WDATA(wdata), .DONE_FLAG_CLR(dclr),
      .SFR_RDATA(rdata), .NV_DONE_FLAG(done), .NV_BUSY(busy)
   );

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Hang guard, well above the roughly 120 cycles the sequence needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // A spare cycle after each strobe keeps a driver from assigning twice per step
   task automatic wr(input logic [2:0] s, input logic [7:0] v);
      sel = s;
      wdata = v;
      we = 1'b1;
      @(posedge clk); #2;
      we = 1'b0;
      @(posedge clk); #2;
   endtask

   task automatic rd(input logic [2:0] s, output logic [7:0] v);
      sel = s;
      re = 1'b1;
      @(posedge clk); #2;
      re = 1'b0;
      v = rdata;
      @(posedge clk); #2;
   endtask

   task automatic keys();
      wr(NVAC_SEL_KEY, NVAC_KEY_FIRST);
      wr(NVAC_SEL_KEY, NVAC_KEY_SECOND);
   endtask

   task automatic wait_idle(input int exp_n);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clk); #2;
         n++;
      end
      chk("busy ends", {7'h00, busy}, 8'h00);
      chk("busy cycles", 8'(n), 8'(exp_n));
   endtask

   task automatic t_por();
      rd(NVAC_SEL_CTRL, d);
      chk("ctrl por", d & 8'h27, 8'h00);
      rd(NVAC_SEL_KEY, d);
      chk("key read", d, 8'h00);
   endtask

   task automatic t_write();
      wr(NVAC_SEL_IDXH, 8'hfd);
      wr(NVAC_SEL_IDXL, 8'h3c);
      wr(NVAC_SEL_BUF, 8'ha5);
      wr(NVAC_SEL_CTRL, 8'h04);
      rd(NVAC_SEL_CTRL, d);
      chk("gate fault", d, 8'h0c);
      keys();
      wr(NVAC_SEL_CTRL, 8'h06);
      chk("busy start", {7'h00, busy}, 8'h01);
      wr(NVAC_SEL_BUF, 8'h11);
      wait_idle(2 * PHASE - 3);
      chk("done set", {7'h00, done}, 8'h01);
      rd(NVAC_SEL_CTRL, d);
      chk("ctrl after", d, 8'h04);
      rd(NVAC_SEL_BUF, d);
      chk("buf locked", d, 8'ha5);
      wr(NVAC_SEL_BUF, 8'h00);
      wr(NVAC_SEL_IDXH, 8'h05);
      wr(NVAC_SEL_CTRL, 8'h05);
      rd(NVAC_SEL_BUF, d);
      chk("read back", d, 8'ha5);
      rd(NVAC_SEL_CTRL, d);
      chk("rd clear", d & 8'h01, 8'h00);
      dclr = 1'b1;
      @(posedge clk); #2;
      dclr = 1'b0;
      chk("done clear", {7'h00, done}, 8'h00);
   endtask

   task automatic t_improper();
      wr(NVAC_SEL_CTRL, 8'h00);
      keys();
      wr(NVAC_SEL_CTRL, 8'h06);
      chk("same write", {7'h00, busy}, 8'h00);
      rd(NVAC_SEL_CTRL, d);
      chk("fault bad", d & 8'h0e, 8'h0c);
      wr(NVAC_SEL_KEY, NVAC_KEY_FIRST);
      wr(NVAC_SEL_BUF, 8'h22);
      wr(NVAC_SEL_KEY, NVAC_KEY_SECOND);
      wr(NVAC_SEL_CTRL, 8'h06);
      chk("disarmed", {7'h00, busy}, 8'h00);
   endtask

   task automatic t_spaces();
      logic [7:0] c [2];
      c = '{8'h81, 8'h41};
      foreach (c[i]) begin
         wr(NVAC_SEL_BUF, 8'h77);
         wr(NVAC_SEL_CTRL, c[i]);
         rd(NVAC_SEL_BUF, d);
         chk("rd refused", d, 8'h77);
         rd(NVAC_SEL_CTRL, d);
         chk("space sel", d & 8'hc1, c[i] & 8'hc0);
      end
      wr(NVAC_SEL_CTRL, 8'h94);
      keys();
      wr(NVAC_SEL_CTRL, 8'h96);
      chk("row start", {7'h00, busy}, 8'h01);
      wait_idle(2 * PHASE - 1);
      rd(NVAC_SEL_CTRL, d);
      chk("row clear", d & 8'h1a, 8'h00);
   endtask

   task automatic t_freeze();
      rd(NVAC_SEL_IDXL, d);
      chk("idx low", d, 8'h3c);
      ce = 1'b0;
      wr(NVAC_SEL_BUF, 8'h3e);
      wr(NVAC_SEL_IDXL, 8'h00);
      rd(NVAC_SEL_BUF, d);
      ce = 1'b1;
      chk("ce rdata", d, 8'h3c);
      rd(NVAC_SEL_IDXL, d);
      chk("ce idx", d, 8'h3c);
      rd(NVAC_SEL_BUF, d);
      chk("ce buf", d, 8'h77);
   endtask

   task automatic t_reset_mid();
      wr(NVAC_SEL_CTRL, 8'h44);
      keys();
      wr(NVAC_SEL_CTRL, 8'h46);
      rst = 1'b1;
      @(posedge clk); #2;
      rst = 1'b0;
      chk("busy reset", {7'h00, busy}, 8'h00);
      rd(NVAC_SEL_CTRL, d);
      chk("fault reset", d & 8'hca, 8'h48);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      #2;
      rst = 1'b0;
      por = 1'b0;
      t_por();
      t_write();
      t_improper();
      t_spaces();
      t_freeze();
      t_reset_mid();
      close_out();
   end
endmodule
`default_nettype wire
